// ---- bench/clk_sel_chk.sv ----
// Assertion checker for the clock select block
`timescale 1ns/1ps
`default_nettype none
module clk_sel_chk
	import clk_sel_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scs_wr_i,
	input wire logic [1:0] scs_wdata_i,
	input wire logic ifs_wr_i,
	input wire logic [3:0] ifs_wdata_i,
	input wire logic sleep_i,
	input wire logic sys_clk_o,
	input wire logic start_timer_done_flag_o,
	input wire logic [1:0] sys_clk_source_select_o,
	input wire logic [3:0] internal_freq_select_o,
	input wire logic [1:0] active_src_o,
	input wire logic clk_switching_o,
	input wire logic pll_ready_o,
	input wire logic bus_tick_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Fields leave reset at their documented values
	a_fields_reset: assert property ($fell(rst_i) |->
		sys_clk_source_select_o == SCS_RESET &&
		internal_freq_select_o == IFS_RESET) else $error("reset fields");
	// Only software writes move the select field, never a switch
	a_sel_write: assert property (scs_wr_i |=>
		sys_clk_source_select_o == $past(scs_wdata_i)) else $error("sel wr");
	a_sel_stable: assert property (!scs_wr_i |=>
		$stable(sys_clk_source_select_o)) else $error("sel moved");
	a_freq_write: assert property (ifs_wr_i |=>
		internal_freq_select_o == $past(ifs_wdata_i)) else $error("freq wr");
	// Flag only while the external source runs or is being handed over
	a_flag_source: assert property (start_timer_done_flag_o &&
		!clk_switching_o |-> active_src_o == SRC_EXT)
		else $error("flag src");
	a_flag_rise: assert property ($rose(start_timer_done_flag_o) |->
		clk_switching_o) else $error("flag rise");
	// With no active source, as before the first handover or in sleep, the clock stays low
	a_hold_low: assert property (active_src_o == SRC_NONE |->
		!sys_clk_o) else $error("clock not held low");
	a_sleep_abort: assert property (sleep_i ##1 sleep_i |->
		!start_timer_done_flag_o && active_src_o == SRC_NONE)
		else $error("sleep abort");
	a_int_select: assert property (sys_clk_source_select_o[1] &&
		!clk_switching_o |-> active_src_o == SRC_INT) else $error("int");
	a_sec_select: assert property (active_src_o == SRC_SEC &&
		!clk_switching_o |-> sys_clk_source_select_o == SCS_SECONDARY)
		else $error("sec");
	a_bus_gate: assert property (!pll_ready_o ##1 !pll_ready_o |->
		!bus_tick_o) else $error("bus tick unlocked");
	c_flag: cover property ($rose(start_timer_done_flag_o));
	c_sec: cover property (active_src_o == SRC_SEC);
	c_sleep: cover property (sleep_i ##1 sleep_i);
endmodule
`default_nettype wire

// ---- bench/osc_model.sv ----
// Free-running oscillator sources seen by the clock select block
`timescale 1ns/1ps
`default_nettype none
module osc_model (
	input wire logic clk_i,
	output logic ext_o,
	output logic int_o,
	output logic sec_o,
	output logic pll_o
);
	int cnt = 0;
	// Levels move on the falling edge so the block samples them settled
	always @(negedge clk_i) begin
		cnt <= cnt + 1;
	end
	// Periods of 4 and 6 cycles keep every source below half the clock rate
	assign ext_o = (cnt % 4) < 2;
	assign pll_o = ((cnt + 1) % 4) < 2;
	assign int_o = (cnt % 6) < 3;
	assign sec_o = ((cnt + 2) % 6) < 3;
endmodule
`default_nettype wire

// ---- bench/system_clock_select_two_speed_tb.sv ----
// Self-checking bench for the clock select block
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_two_speed_tb;
	import clk_sel_pkg::*;
	logic clk_sys_i, rst_i, two_speed_enable_cfg_i, clock_fail_monitor_en_i;
	logic bus_low_speed_clk_select_i, bus_full_speed_i, pll_mult3_i;
	logic pll_en_i, tuning_active_i, scs_wr_i, ifs_wr_i, sleep_i;
	logic powerup_done_i, secondary_osc_enable_i, ext_osc_i, int_osc_i;
	logic sec_osc_i, pll_clk_i, sys_clk_o, start_timer_done_flag_o;
	logic secondary_osc_ready_flag_o, clk_switching_o, pll_ready_o;
	logic bus_tick_o, sys_tick_o, bus_cfg_valid_o;
	logic [2:0] osc_config_select_i;
	logic [1:0] cpu_clk_divider_cfg_i, osc_in_freq_i, scs_wdata_i;
	logic [1:0] sys_clk_source_select_o, active_src_o;
	logic [3:0] ifs_wdata_i, internal_freq_select_o;
	int mismatches, comparisons;

	system_clock_select_two_speed #(.PLL_LOCK_CYCLES(20))
		system_clock_select_two_speed_i (.*);
	osc_model osc_model_i (.clk_i(clk_sys_i), .ext_o(ext_osc_i),
		.int_o(int_osc_i), .sec_o(sec_osc_i), .pll_o(pll_clk_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wrap_up;
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// A source that never arrives ends the run instead of hanging it
	task wait_src(input logic [1:0] s, input int lim);
		int k;
		for (k = 0; k < lim && active_src_o !== s; k++)
			cyc(1);
		if (active_src_o !== s) begin
			chk(active_src_o, s);
			wrap_up;
		end
	endtask

	task reboot(input logic [2:0] cfg, input logic ts, input logic fm);
		osc_config_select_i = cfg;
		two_speed_enable_cfg_i = ts;
		clock_fail_monitor_en_i = fm;
		rst_i = 1'b1;
		cyc(8);
		rst_i = 1'b0;
	endtask

	task wr_scs(input logic [1:0] d);
		scs_wdata_i = d;
		scs_wr_i = 1'b1;
		cyc(1);
		scs_wr_i = 1'b0;
		cyc(1);
	endtask

	// Cycles between two tick pulses, the first gap skipped
	task gap(input logic bus, output int n);
		int k;
		repeat (2) begin
			for (k = 0; k < 300 && (bus ? bus_tick_o : sys_tick_o) !== 1; k++)
				cyc(1);
			cyc(1);
			n = 1;
			while (n < 300 && (bus ? bus_tick_o : sys_tick_o) !== 1'b1) begin
				cyc(1);
				n++;
			end
			// A tick that never comes ends the run
			if (k == 300 || n == 300) begin
				chk(8'(k == 300 || n == 300), 8'h00);
				wrap_up;
			end
		end
	endtask

	task t_two_speed;
		int n;
		reboot(OSC_HIGH_SPEED_XTAL, 1'b1, 1'b0);
		cyc(30);
		chk(active_src_o, SRC_INT);
		cyc(3950);
		chk(start_timer_done_flag_o, 1'b0);
		wait_src(SRC_EXT, 400);
		chk(start_timer_done_flag_o, 1'b1);
		chk(sys_clk_source_select_o, SCS_CONFIGURED);
		// External source has a four-cycle period, half of it high
		n = 0;
		repeat (8) begin
			cyc(1);
			n += sys_clk_o;
		end
		chk(8'(n), 8'h04);
	endtask

	task t_sleep;
		reboot(OSC_LOW_POWER_XTAL, 1'b1, 1'b0);
		cyc(100);
		sleep_i = 1'b1;
		cyc(5);
		chk(start_timer_done_flag_o, 1'b0);
		chk(active_src_o, SRC_NONE);
		sleep_i = 1'b0;
		cyc(30);
		chk(active_src_o, SRC_INT);
	endtask

	task t_modes;
		reboot(OSC_EXT_HIGH_POWER, 1'b1, 1'b0);
		wait_src(SRC_EXT, 40);
		chk(clk_switching_o, 1'b0);
		reboot(OSC_STD_XTAL, 1'b0, 1'b0);
		cyc(30);
		chk(active_src_o, SRC_NONE);
		reboot(OSC_STD_XTAL, 1'b0, 1'b1);
		cyc(30);
		chk(active_src_o, SRC_INT);
	endtask

	task t_secondary;
		int k;
		reboot(OSC_HIGH_SPEED_XTAL, 1'b0, 1'b0);
		secondary_osc_enable_i = 1'b1;
		cyc(5000);
		chk(secondary_osc_ready_flag_o, 1'b0);
		for (k = 0; k < 2000 && secondary_osc_ready_flag_o !== 1; k++)
			cyc(1);
		chk(secondary_osc_ready_flag_o, 1'b1);
		if (secondary_osc_ready_flag_o !== 1'b1)
			wrap_up;
		wr_scs(SCS_SECONDARY);
		chk(clk_switching_o, 1'b1);
		wait_src(SRC_SEC, 6600);
		chk(start_timer_done_flag_o, 1'b0);
		wr_scs(2'h2);
		wait_src(SRC_INT, 60);
		ifs_wdata_i = 4'h3;
		ifs_wr_i = 1'b1;
		cyc(1);
		ifs_wr_i = 1'b0;
		chk(internal_freq_select_o, 4'h3);
		reboot(OSC_HIGH_SPEED_XTAL, 1'b0, 1'b0);
		chk(sys_clk_source_select_o, SCS_RESET);
		chk(internal_freq_select_o, IFS_RESET);
	endtask

	task t_ticks;
		int n;
		int i;
		chk(pll_ready_o, 1'b0);
		cyc(25);
		chk(pll_ready_o, 1'b1);
		for (i = 0; i < 4; i++) begin
			cpu_clk_divider_cfg_i = 2'(i);
			gap(1'b0, n);
			chk(8'(n), 8'(4 * ((i == 3) ? 6 : i + 1)));
		end
		gap(1'b1, n);
		chk(8'(n), 8'h20);
		bus_low_speed_clk_select_i = 1'b0;
		gap(1'b1, n);
		chk(8'(n), 8'h10);
		bus_full_speed_i = 1'b1;
		gap(1'b1, n);
		chk(8'(n), 8'h04);
		osc_in_freq_i = FREQ_8MHZ;
		cyc(3);
		chk(bus_cfg_valid_o, 1'b0);
		osc_in_freq_i = FREQ_16MHZ;
		cyc(3);
		chk(bus_cfg_valid_o, 1'b1);
		osc_config_select_i = OSC_INTERNAL;
		cyc(3);
		chk(bus_cfg_valid_o, 1'b0);
		tuning_active_i = 1'b1;
		cyc(3);
		chk(bus_cfg_valid_o, 1'b1);
	endtask

	// Low-speed 16 MHz times three setup held unless a scenario moves it
	initial begin
		rst_i = 1'b1;
		scs_wr_i = 1'b0;
		scs_wdata_i = 2'h0;
		ifs_wr_i = 1'b0;
		ifs_wdata_i = 4'h0;
		sleep_i = 1'b0;
		powerup_done_i = 1'b1;
		secondary_osc_enable_i = 1'b0;
		cpu_clk_divider_cfg_i = 2'h0;
		bus_low_speed_clk_select_i = 1'b1;
		bus_full_speed_i = 1'b0;
		osc_in_freq_i = FREQ_16MHZ;
		pll_mult3_i = 1'b1;
		pll_en_i = 1'b1;
		tuning_active_i = 1'b0;
		mismatches = 0;
		comparisons = 0;
		t_two_speed;
		t_sleep;
		t_modes;
		t_secondary;
		t_ticks;
		wrap_up;
	end
endmodule

bind system_clock_select_two_speed clk_sel_chk clk_sel_chk_i (.*);
`default_nettype wire

// ---- src/clk_sel_pkg.sv ----
// Constants and types for the system clock select and two-speed start-up block
package clk_sel_pkg;

	// Oscillator configuration codes
	localparam logic [2:0] OSC_LOW_POWER_XTAL = 3'h0;
	localparam logic [2:0] OSC_STD_XTAL = 3'h1;
	localparam logic [2:0] OSC_HIGH_SPEED_XTAL = 3'h2;
	localparam logic [2:0] OSC_EXT_HIGH_POWER = 3'h3;
	localparam logic [2:0] OSC_INTERNAL = 3'h4;

	// Source select field values and reset values
	localparam logic [1:0] SCS_CONFIGURED = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [1:0] SCS_RESET = 2'h0;
	localparam logic [3:0] IFS_RESET = 4'h7;

	// Input frequency codes of the multiplied path
	localparam logic [1:0] FREQ_8MHZ = 2'h0;
	localparam logic [1:0] FREQ_12MHZ = 2'h1;
	localparam logic [1:0] FREQ_16MHZ = 2'h2;

	// Low-speed bus divide terminal counts (48 MHz / 8, 24 MHz / 4)
	localparam logic [2:0] LS_TC_SEL1 = 3'h7;
	localparam logic [2:0] LS_TC_SEL0 = 3'h3;

	// System divider codes and terminal counts (divide by 1, 2, 3, 6)
	localparam logic [1:0] CPU_CLK_DIVIDER_CFG_1 = 2'h0;
	localparam logic [1:0] CPU_CLK_DIVIDER_CFG_2 = 2'h1;
	localparam logic [1:0] CPU_CLK_DIVIDER_CFG_3 = 2'h2;
	localparam logic [2:0] DIV_TC_1 = 3'h0;
	localparam logic [2:0] DIV_TC_2 = 3'h1;
	localparam logic [2:0] DIV_TC_3 = 3'h2;
	localparam logic [2:0] DIV_TC_6 = 3'h5;

	// Edge counts of the settling delays
	localparam int CNT_W = 11;
	localparam int PLL_CNT_W = 15;
	localparam logic [10:0] OST_COUNT = 11'h400;
	localparam logic [10:0] EC_WAKE_EDGES = 11'h002;
	localparam logic [10:0] EC_SWITCH_EDGES = 11'h001;

	// Times and the cycle counts derived from the 10 MHz clock
	localparam int SYS_CLK_PERIOD_NS = 100;
	localparam int HFINT_SETTLE_NS = 2000;
	localparam int HFINT_SETTLE_CYC =
		(HFINT_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam logic [10:0] HFINT_SETTLE_LIM = 11'(HFINT_SETTLE_CYC);
	localparam int PLL_LOCK_US = 2000;
	localparam int PLL_LOCK_CYC =
		(PLL_LOCK_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_START = 3'h0,
		ST_RUN = 3'h1,
		ST_WAIT = 3'h2,
		ST_SYNC = 3'h3,
		ST_HOLD = 3'h4,
		ST_SLEEP = 3'h5
	} clk_fsm_t;

	typedef enum logic [1:0] {
		SRC_INT = 2'h0,
		SRC_EXT = 2'h1,
		SRC_SEC = 2'h2,
		SRC_NONE = 2'h3
	} clk_src_t;

	typedef enum logic [1:0] {
		CS_SYS = 2'h0,
		CS_EXT = 2'h1,
		CS_SEC = 2'h2
	} cnt_src_t;

endpackage

// ---- src/sys_clk_divider.sv ----
// Divides the multiplied clock tick stream by 1, 2, 3 or 6
`timescale 1ns/1ps
`default_nettype none
module sys_clk_divider
	import clk_sel_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic [1:0] div_sel_i,
	output logic tick_o
);

	typedef struct packed {
		logic [2:0] cnt;
		logic tick;
	} div_state_t;

	div_state_t s_r;
	div_state_t s_nxt;
	logic [2:0] tc;

	// Terminal count of the selected division
	always_comb begin
		case (div_sel_i)
			CPU_CLK_DIVIDER_CFG_1: tc = DIV_TC_1;
			CPU_CLK_DIVIDER_CFG_2: tc = DIV_TC_2;
			CPU_CLK_DIVIDER_CFG_3: tc = DIV_TC_3;
			default: tc = DIV_TC_6;
		endcase
	end

	// Count input ticks, emit one pulse per period
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (tick_i) begin
			if (s_r.cnt >= tc) begin
				s_nxt.cnt = 3'h0;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.cnt = 3'(s_r.cnt + 3'h1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = s_r.tick;

endmodule
`default_nettype wire

// ---- src/system_clock_select_two_speed.sv ----
// System clock source selection with two-speed start-up
`timescale 1ns/1ps
`default_nettype none
module system_clock_select_two_speed
	import clk_sel_pkg::*;
#(
	parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [2:0] osc_config_select_i,
	input wire logic two_speed_enable_cfg_i,
	input wire logic clock_fail_monitor_en_i,
	input wire logic [1:0] cpu_clk_divider_cfg_i,
	input wire logic bus_low_speed_clk_select_i,
	input wire logic bus_full_speed_i,
	input wire logic [1:0] osc_in_freq_i,
	input wire logic pll_mult3_i,
	input wire logic pll_en_i,
	input wire logic tuning_active_i,
	input wire logic scs_wr_i,
	input wire logic [1:0] scs_wdata_i,
	input wire logic ifs_wr_i,
	input wire logic [3:0] ifs_wdata_i,
	input wire logic sleep_i,
	input wire logic powerup_done_i,
	input wire logic secondary_osc_enable_i,
	input wire logic ext_osc_i,
	input wire logic int_osc_i,
	input wire logic sec_osc_i,
	input wire logic pll_clk_i,
	output logic sys_clk_o,
	output logic start_timer_done_flag_o,
	output logic secondary_osc_ready_flag_o,
	output logic [1:0] sys_clk_source_select_o,
	output logic [3:0] internal_freq_select_o,
	output logic [1:0] active_src_o,
	output logic clk_switching_o,
	output logic pll_ready_o,
	output logic bus_tick_o,
	output logic sys_tick_o,
	output logic bus_cfg_valid_o
);

	typedef struct packed {
		clk_fsm_t fsm;
		clk_src_t cur;
		clk_src_t tgt;
		cnt_src_t csrc;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] lim;
		logic prev_ext;
		logic prev_int;
		logic prev_sec;
		logic prev_pll;
		logic sys_clk;
		logic flag;
		logic [1:0] sys_clk_source_select;
		logic [3:0] ifs;
		logic [CNT_W-1:0] sec_cnt;
		logic sec_ready;
		logic [PLL_CNT_W-1:0] pll_cnt;
		logic pll_ready;
		logic [2:0] bus_div;
		logic bus_tick;
		logic cfg_valid;
		logic switching;
	} clk_state_t;

	localparam clk_state_t S_RST = '{fsm: ST_START, cur: SRC_NONE,
		tgt: SRC_NONE, csrc: CS_SYS, sys_clk_source_select: SCS_RESET, ifs: IFS_RESET,
		default: '0};
	localparam logic [PLL_CNT_W-1:0] PLL_LIM = PLL_CNT_W'(PLL_LOCK_CYCLES);
	clk_state_t s_r;
	clk_state_t s_nxt;
	logic ext_rise;
	logic sec_rise;
	logic pll_tick;
	logic xtal;
	logic two_speed_on;
	logic cnt_tick;
	logic [1:0] scs_now;
	clk_src_t want;

	function automatic logic rose(input logic prev, input logic now);
		rose = !prev && now;
	endfunction
	function automatic logic is_crystal(input logic [2:0] cfg);
		is_crystal = (cfg == OSC_LOW_POWER_XTAL) || (cfg == OSC_STD_XTAL) ||
			(cfg == OSC_HIGH_SPEED_XTAL);
	endfunction
	// Level of a source; an absent source reads low
	function automatic logic src_level(input clk_src_t src, input logic e,
		input logic i, input logic c);
		case (src)
			SRC_EXT: src_level = e;
			SRC_INT: src_level = i;
			SRC_SEC: src_level = c;
			default: src_level = 1'b0;
		endcase
	endfunction

	// Falling edge of a source between the last and current samples
	function automatic logic src_fell(input clk_src_t src,
		input clk_state_t st);
		src_fell = src_level(src, st.prev_ext, st.prev_int, st.prev_sec) &&
			!src_level(src, ext_osc_i, int_osc_i, sec_osc_i);
	endfunction

	// Settling length for a target source
	function automatic logic [CNT_W-1:0] dly_lim(input clk_src_t src,
		input logic [2:0] cfg, input logic from_rst);
		if (src == SRC_INT) begin
			dly_lim = HFINT_SETTLE_LIM;
		end else if (src == SRC_EXT && !is_crystal(cfg)) begin
			dly_lim = from_rst ? EC_WAKE_EDGES : EC_SWITCH_EDGES;
		end else begin
			dly_lim = OST_COUNT;
		end
	endfunction

	// What the settling counter counts for a target source
	function automatic cnt_src_t dly_src(input clk_src_t src);
		case (src)
			SRC_EXT: dly_src = CS_EXT;
			SRC_SEC: dly_src = CS_SEC;
			default: dly_src = CS_SYS;
		endcase
	endfunction

	assign ext_rise = rose(s_r.prev_ext, ext_osc_i);
	assign sec_rise = rose(s_r.prev_sec, sec_osc_i);
	assign pll_tick = rose(s_r.prev_pll, pll_clk_i) && s_r.pll_ready;
	assign xtal = is_crystal(osc_config_select_i);
	// Fail monitor forces two-speed on without the enable bit
	assign two_speed_on = xtal && (s_r.sys_clk_source_select == SCS_CONFIGURED) &&
		(two_speed_enable_cfg_i || clock_fail_monitor_en_i);
	assign cnt_tick = (s_r.csrc == CS_SYS) ||
		(s_r.csrc == CS_EXT && ext_rise) || (s_r.csrc == CS_SEC && sec_rise);

	// Source demanded by the select field; a write acts in its own cycle
	assign scs_now = scs_wr_i ? scs_wdata_i : s_r.sys_clk_source_select;
	assign want = scs_now[1] ? SRC_INT :
		(scs_now == SCS_SECONDARY) ? SRC_SEC :
		(osc_config_select_i == OSC_INTERNAL) ? SRC_INT : SRC_EXT;

	// Next state of the whole block
	always_comb begin
		s_nxt = s_r;
		s_nxt.prev_ext = ext_osc_i;
		s_nxt.prev_int = int_osc_i;
		s_nxt.prev_sec = sec_osc_i;
		s_nxt.prev_pll = pll_clk_i;
		s_nxt.bus_tick = 1'b0;

		// Software fields; automatic switches never touch them
		if (scs_wr_i) begin
			s_nxt.sys_clk_source_select = scs_wdata_i;
		end
		if (ifs_wr_i) begin
			s_nxt.ifs = ifs_wdata_i;
		end

		// Secondary oscillator is usable after its own start-up count
		if (!secondary_osc_enable_i) begin
			s_nxt.sec_cnt = '0;
			s_nxt.sec_ready = 1'b0;
		end else if (sec_rise && !s_r.sec_ready) begin
			if (11'(s_r.sec_cnt + 11'h1) >= OST_COUNT) begin
				s_nxt.sec_ready = 1'b1;
			end
			s_nxt.sec_cnt = 11'(s_r.sec_cnt + 11'h1);
		end

		// Multiplier lock wait after enabling
		if (!pll_en_i) begin
			s_nxt.pll_cnt = '0;
			s_nxt.pll_ready = 1'b0;
		end else if (!s_r.pll_ready) begin
			if (15'(s_r.pll_cnt + 15'h1) >= PLL_LIM) begin
				s_nxt.pll_ready = 1'b1;
			end
			s_nxt.pll_cnt = 15'(s_r.pll_cnt + 15'h1);
		end

		// Bus clock: 48 MHz straight, or 6 MHz by 8 or by 4
		if (pll_tick) begin
			if (bus_full_speed_i) begin
				s_nxt.bus_tick = 1'b1;
				s_nxt.bus_div = 3'h0;
			end else if (s_r.bus_div >= (bus_low_speed_clk_select_i ?
				LS_TC_SEL1 : LS_TC_SEL0)) begin
				s_nxt.bus_tick = 1'b1;
				s_nxt.bus_div = 3'h0;
			end else begin
				s_nxt.bus_div = 3'(s_r.bus_div + 3'h1);
			end
		end

		// Valid bus clock combinations only
		s_nxt.cfg_valid = s_r.pll_ready &&
			(osc_config_select_i == OSC_INTERNAL ||
			osc_config_select_i == OSC_EXT_HIGH_POWER ||
			osc_config_select_i == OSC_HIGH_SPEED_XTAL) &&
			(bus_full_speed_i ?
			(!bus_low_speed_clk_select_i &&
			((osc_in_freq_i == FREQ_16MHZ && pll_mult3_i) ||
			(osc_in_freq_i == FREQ_12MHZ && !pll_mult3_i &&
			osc_config_select_i != OSC_INTERNAL)) &&
			(osc_config_select_i != OSC_INTERNAL || tuning_active_i)) :
			((osc_in_freq_i == FREQ_16MHZ && pll_mult3_i &&
			bus_low_speed_clk_select_i) ||
			(osc_in_freq_i == FREQ_12MHZ && !pll_mult3_i &&
			bus_low_speed_clk_select_i &&
			osc_config_select_i != OSC_INTERNAL) ||
			(osc_in_freq_i == FREQ_8MHZ && pll_mult3_i &&
			!bus_low_speed_clk_select_i)));

		// Switching sequencer
		case (s_r.fsm)
			ST_START: begin
				if (powerup_done_i) begin
					s_nxt.cnt = '0;
					s_nxt.fsm = ST_WAIT;
					s_nxt.tgt = want;
					if (two_speed_on) begin
						s_nxt.cur = SRC_INT;
						s_nxt.lim = OST_COUNT;
						s_nxt.csrc = CS_EXT;
					end else begin
						s_nxt.cur = SRC_NONE;
						s_nxt.lim = dly_lim(want, osc_config_select_i,
							1'b1);
						s_nxt.csrc = dly_src(want);
					end
				end
			end
			ST_RUN: begin
				if (want != s_r.cur) begin
					s_nxt.fsm = ST_WAIT;
					s_nxt.tgt = want;
					s_nxt.cnt = '0;
					s_nxt.lim = dly_lim(want, osc_config_select_i,
						1'b0);
					s_nxt.csrc = dly_src(want);
				end
			end
			ST_WAIT: begin
				if (want != s_r.tgt) begin
					// Software changed its mind mid-settle
					if (want == s_r.cur) begin
						s_nxt.fsm = ST_RUN;
					end else begin
						s_nxt.tgt = want;
						s_nxt.cnt = '0;
						s_nxt.lim = dly_lim(want, osc_config_select_i, 1'b0);
						s_nxt.csrc = dly_src(want);
					end
				end else if (cnt_tick) begin
					if (11'(s_r.cnt + 11'h1) >= s_r.lim) begin
						s_nxt.cnt = '0;
						s_nxt.fsm = ST_SYNC;
					end else begin
						s_nxt.cnt = 11'(s_r.cnt + 11'h1);
					end
				end
			end
			ST_SYNC: begin
				// Leave the old clock only right after its falling edge
				if (s_r.cur == SRC_NONE || src_fell(s_r.cur, s_r)) begin
					s_nxt.fsm = ST_HOLD;
					s_nxt.flag = (s_r.tgt == SRC_EXT);
				end
			end
			ST_HOLD: begin
				// Clock held low until the new source falls
				if (src_fell(s_r.tgt, s_r)) begin
					s_nxt.cur = s_r.tgt;
					s_nxt.fsm = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (!sleep_i) begin
					s_nxt.fsm = ST_START;
				end
			end
			default: begin
				s_nxt.fsm = ST_START;
			end
		endcase

		// Sleep aborts the settling count and drops the clock
		if (sleep_i) begin
			s_nxt.fsm = ST_SLEEP;
			s_nxt.cur = SRC_NONE;
			s_nxt.cnt = '0;
			s_nxt.flag = 1'b0;
		end

		s_nxt.switching = (s_nxt.fsm != ST_RUN);
		// Output clock follows the current source in run, wait and sync states, else stays low
		if (s_nxt.fsm == ST_RUN || s_nxt.fsm == ST_WAIT ||
			s_nxt.fsm == ST_SYNC) begin
			s_nxt.sys_clk = src_level(s_nxt.cur, ext_osc_i, int_osc_i,
				sec_osc_i);
		end else begin
			s_nxt.sys_clk = 1'b0;
		end
	end

	// Every reset clears the select field and loads 500 kHz
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= S_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// System clock rate is the multiplied clock divided
	sys_clk_divider sys_clk_divider_i (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.tick_i(pll_tick),
		.div_sel_i(cpu_clk_divider_cfg_i),
		.tick_o(sys_tick_o)
	);

	assign sys_clk_o = s_r.sys_clk;
	assign start_timer_done_flag_o = s_r.flag;
	assign secondary_osc_ready_flag_o = s_r.sec_ready;
	assign sys_clk_source_select_o = s_r.sys_clk_source_select;
	assign internal_freq_select_o = s_r.ifs;
	assign active_src_o = s_r.cur;
	assign clk_switching_o = s_r.switching;
	assign pll_ready_o = s_r.pll_ready;
	assign bus_tick_o = s_r.bus_tick;
	assign bus_cfg_valid_o = s_r.cfg_valid;

endmodule
`default_nettype wire
